// [core/sfbs_pkg.sv]
`default_nettype none
package sfbs_pkg;
   localparam int ADDR_W     = 18;
   localparam int LANES      = 2;
   localparam int LANE_W     = 9;
   localparam int DATA_W     = LANES * LANE_W;
   localparam int BURST_W    = 2;
   localparam int CLK_PERIOD_NS = 10;
   localparam logic [1:0] CNT_RESET = 2'h0;

   typedef enum logic [1:0] {
      SFBS_IDLE  = 2'b00,
      SFBS_READ  = 2'b01,
      SFBS_WRITE = 2'b10,
      SFBS_SLEEP = 2'b11
   } sfbs_state_t;
endpackage
`default_nettype wire

// [core/sfbs_mem.sv]
`default_nettype none
module sfbs_mem #(
   parameter int ADDR_W = sfbs_pkg::ADDR_W,
   parameter int LANES  = sfbs_pkg::LANES,
   parameter int LANE_W = sfbs_pkg::LANE_W
) (
   input  wire logic                      clock_in,
   input  wire logic                      clk_en_in,
   input  wire logic [ADDR_W-1:0]         addr_in,
   input  wire logic [LANES-1:0]          lane_we_in,
   input  wire logic [LANES*LANE_W-1:0]   wdata_in,
   output logic      [LANES*LANE_W-1:0]   rdata_out
);
   logic [LANES*LANE_W-1:0] mem_r [2**ADDR_W];

   // Gated lanes keep their contents
   always_ff @(posedge clock_in) begin
      if (clk_en_in) begin
         for (int i = 0; i < LANES; i++) begin
            if (lane_we_in[i]) begin
               mem_r[addr_in][i*LANE_W +: LANE_W] <= wdata_in[i*LANE_W +: LANE_W];
            end
         end
      end
   end

   // Flow-through read path
   assign rdata_out = mem_r[addr_in];
endmodule
`default_nettype wire

// [core/sfbs_top.sv]
`default_nettype none
module sfbs_top #(
   parameter int ADDR_W = sfbs_pkg::ADDR_W,
   parameter int LANES  = sfbs_pkg::LANES,
   parameter int LANE_W = sfbs_pkg::LANE_W
) (
   input  wire logic                    clock_in,
   input  wire logic                    reset_n_in,
   input  wire logic [ADDR_W-1:0]       addr_in,
   input  wire logic                    ctrl_addr_strobe_n_in,
   input  wire logic                    proc_addr_strobe_n_in,
   input  wire logic                    burst_advance_n_in,
   input  wire logic                    burst_order_sel_in,
   input  wire logic [LANES-1:0]        byte_write_n_in,
   input  wire logic                    global_write_n_in,
   input  wire logic                    write_gate_n_in,
   input  wire logic                    primary_select_n_in,
   input  wire logic                    expand_select_hi_in,
   input  wire logic                    expand_select_lo_n_in,
   input  wire logic                    output_enable_n_in,
   input  wire logic                    sleep_request_in,
   input  wire logic [LANES*LANE_W-1:0] data_lanes_in,
   output logic      [LANES*LANE_W-1:0] data_lanes_out,
   output logic                         data_lanes_oe_n_out,
   output logic                         selected_out,
   output logic                         low_power_out
);
   localparam int DW = LANES * LANE_W;
   localparam int BW = sfbs_pkg::BURST_W;

   sfbs_pkg::sfbs_state_t state_r;
   sfbs_pkg::sfbs_state_t state_nxt;
   logic [ADDR_W-1:0]     base_r;
   logic [BW-1:0]         cnt_r;
   logic [BW-1:0]         cnt_nxt;
   logic [ADDR_W-1:0]     acc_addr;
   logic [LANES-1:0]      lane_we;
   logic [LANES-1:0]      lane_we_r;
   logic [DW-1:0]         wdata_r;
   logic [DW-1:0]         rdata;
   logic                  chip_en;
   logic                  proc_take;
   logic                  ctrl_take;
   logic                  strobe_take;
   logic                  is_write;
   logic                  mem_en;

   // Step function for the two sequenced address bits
   function automatic logic [BW-1:0] burst_step(input logic [BW-1:0] cnt);
      burst_step = cnt + 2'h1;
   endfunction

   // Full enable decode
   assign chip_en   = !primary_select_n_in && expand_select_hi_in
                      && !expand_select_lo_n_in;
   // Primary select high masks the processor strobe
   assign proc_take = !proc_addr_strobe_n_in && !primary_select_n_in;
   assign ctrl_take = proc_addr_strobe_n_in ? !ctrl_addr_strobe_n_in
                      : (primary_select_n_in && !ctrl_addr_strobe_n_in);
   assign strobe_take = proc_take || ctrl_take;
   assign is_write  = !global_write_n_in
                      || (!write_gate_n_in && (byte_write_n_in != '1));

   always_comb begin
      lane_we = '0;
      if (!global_write_n_in) begin
         lane_we = '1;
      end else if (!write_gate_n_in) begin
         lane_we = ~byte_write_n_in;
      end
   end

   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      if (sleep_request_in) begin
         state_nxt = sfbs_pkg::SFBS_SLEEP;
      end else if (strobe_take) begin
         cnt_nxt = cnt_reset_f();
         if (!chip_en) begin
            state_nxt = sfbs_pkg::SFBS_IDLE;
         end else if (proc_take) begin
            state_nxt = sfbs_pkg::SFBS_READ;
         end else if (is_write) begin
            state_nxt = sfbs_pkg::SFBS_WRITE;
         end else begin
            state_nxt = sfbs_pkg::SFBS_READ;
         end
      end else if (state_r == sfbs_pkg::SFBS_READ || state_r == sfbs_pkg::SFBS_WRITE) begin
         if (!burst_advance_n_in) begin
            cnt_nxt = burst_step(cnt_r);
         end
         // Advance high holds the count
         state_nxt = is_write ? sfbs_pkg::SFBS_WRITE : sfbs_pkg::SFBS_READ;
      end
   end

   function automatic logic [BW-1:0] cnt_reset_f();
      cnt_reset_f = sfbs_pkg::CNT_RESET;
   endfunction

   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state_r <= sfbs_pkg::SFBS_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         cnt_r <= sfbs_pkg::CNT_RESET;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   // Address, data and lane enables are registered
   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         base_r    <= '0;
         wdata_r   <= '0;
         lane_we_r <= '0;
      end else if (!sleep_request_in) begin
         if (strobe_take) begin
            base_r <= addr_in;
         end
         wdata_r   <= data_lanes_in;
         lane_we_r <= (state_nxt == sfbs_pkg::SFBS_WRITE) ? lane_we : '0;
      end
   end

   // Low bits from the counter, linear adds and interleaved xors
   always_comb begin
      acc_addr = base_r;
      if (burst_order_sel_in) begin
         acc_addr[BW-1:0] = base_r[BW-1:0] ^ cnt_r;
      end else begin
         acc_addr[BW-1:0] = base_r[BW-1:0] + cnt_r;
      end
   end

   assign mem_en = !sleep_request_in && (state_r == sfbs_pkg::SFBS_WRITE);

   sfbs_mem #(
      .ADDR_W (ADDR_W),
      .LANES  (LANES),
      .LANE_W (LANE_W)
   ) u_mem (
      .clock_in   (clock_in),
      .clk_en_in  (mem_en),
      .addr_in    (acc_addr),
      .lane_we_in (lane_we_r),
      .wdata_in   (wdata_r),
      .rdata_out  (rdata)
   );

   assign data_lanes_out = rdata;
   // Drive only on reads with output enable low and awake
   assign data_lanes_oe_n_out = !(state_r == sfbs_pkg::SFBS_READ && !output_enable_n_in
                                  && !sleep_request_in);
   assign selected_out  = (state_r == sfbs_pkg::SFBS_READ) || (state_r == sfbs_pkg::SFBS_WRITE);
   assign low_power_out = (state_r == sfbs_pkg::SFBS_SLEEP);

   a_sleep_floats: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      sleep_request_in |-> data_lanes_oe_n_out) else $error("lanes driven in sleep");
   a_sleep_holds: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (state_r == sfbs_pkg::SFBS_SLEEP && !strobe_take) |=> low_power_out)
      else $error("left low power without command");
   a_deselect_cs: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (primary_select_n_in && !ctrl_addr_strobe_n_in && proc_addr_strobe_n_in
       && !sleep_request_in) |=> !selected_out) else $error("no deselect");
   a_proc_ignored: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (primary_select_n_in && !proc_addr_strobe_n_in && ctrl_addr_strobe_n_in
       && !sleep_request_in && selected_out) |=> selected_out)
      else $error("processor strobe not blocked");
   a_expand_desel: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (strobe_take && !expand_select_hi_in && !sleep_request_in) |=> !selected_out)
      else $error("expansion select ignored");
   a_write_start: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (ctrl_take && !proc_take && chip_en && is_write && !sleep_request_in)
      |=> state_r == sfbs_pkg::SFBS_WRITE && cnt_r == 2'h0) else $error("write not begun");
   a_proc_read: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (proc_take && chip_en && !sleep_request_in) |=> state_r == sfbs_pkg::SFBS_READ
      && base_r == $past(addr_in)) else $error("read not begun");
   a_burst_step: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (selected_out && !strobe_take && !burst_advance_n_in && !sleep_request_in)
      |=> cnt_r == $past(cnt_r) + 2'h1) else $error("burst did not step");
   a_burst_hold: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (selected_out && !strobe_take && burst_advance_n_in && !sleep_request_in)
      |=> $stable(cnt_r) && $stable(base_r)) else $error("suspend moved address");
   a_global_all: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (!global_write_n_in && !sleep_request_in && state_nxt == sfbs_pkg::SFBS_WRITE)
      |=> lane_we_r == '1) else $error("global write missed lanes");

   // Steps of a burst used by the properties below
   sequence seq_awake;
      !sleep_request_in;
   endsequence

   sequence seq_take_on;
      strobe_take && chip_en && !sleep_request_in;
   endsequence

   sequence seq_cont;
      selected_out && !strobe_take && !sleep_request_in;
   endsequence

   sequence seq_asleep;
      low_power_out;
   endsequence

   // Start of a burst
   a_ctrl_read: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (seq_take_on ##0 (!proc_take && !is_write))
      |=> state_r == sfbs_pkg::SFBS_READ && base_r == $past(addr_in))
      else $error("controller read not begun");

   a_start_count: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      seq_take_on
      |=> cnt_r == sfbs_pkg::CNT_RESET)
      else $error("burst count not restarted");

   a_first_addr: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      seq_take_on
      |=> acc_addr == $past(addr_in))
      else $error("first access not at external address");

   // Burst sequencing
   a_lin_step: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (seq_cont ##0 (!burst_advance_n_in && !burst_order_sel_in))
      |=> burst_order_sel_in || acc_addr[1:0] == $past(acc_addr[1:0]) + 2'h1)
      else $error("linear step wrong");

   a_ileave_first: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (seq_cont ##0 (!burst_advance_n_in && burst_order_sel_in && cnt_r == 2'h0))
      |=> !burst_order_sel_in || acc_addr[1:0] == ($past(acc_addr[1:0]) ^ 2'h1))
      else $error("interleaved second address wrong");

   a_ileave_second: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (seq_cont ##0 (!burst_advance_n_in && burst_order_sel_in && cnt_r == 2'h1))
      |=> !burst_order_sel_in || acc_addr[1:0] == ($past(acc_addr[1:0]) ^ 2'h3))
      else $error("interleaved third address wrong");

   a_suspend_addr: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (seq_cont ##0 burst_advance_n_in)
      |=> $stable(acc_addr) || burst_order_sel_in != $past(burst_order_sel_in))
      else $error("suspend moved access address");

   a_idle_stays: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (state_r == sfbs_pkg::SFBS_IDLE && !strobe_take && seq_awake)
      |=> !selected_out)
      else $error("burst continued without start");

   // Output enable
   a_oe_float: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      output_enable_n_in
      |-> data_lanes_oe_n_out)
      else $error("lanes driven with output enable high");

   a_write_float: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      state_r == sfbs_pkg::SFBS_WRITE
      |-> data_lanes_oe_n_out)
      else $error("lanes driven in write");

   a_idle_float: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      !selected_out
      |-> data_lanes_oe_n_out)
      else $error("lanes driven while deselected");

   // Write qualification
   a_byte_lanes: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (seq_take_on ##0 (global_write_n_in && !write_gate_n_in && is_write
                        && proc_addr_strobe_n_in))
      |=> lane_we_r == ~$past(byte_write_n_in))
      else $error("byte lanes not honoured");

   a_read_no_lanes: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (seq_awake ##0 state_nxt == sfbs_pkg::SFBS_READ)
      |=> lane_we_r == '0)
      else $error("lane enabled on read");

   // Sleep
   a_sleep_no_write: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      sleep_request_in
      |-> !mem_en)
      else $error("array written in sleep");

   a_sleep_enter: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      sleep_request_in
      |=> low_power_out)
      else $error("sleep not entered");

   a_wake_cmd: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (seq_asleep ##0 seq_take_on)
      |=> !low_power_out)
      else $error("command did not wake");

   // Chip selects
   a_expand_lo: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (strobe_take && expand_select_lo_n_in && seq_awake)
      |=> !selected_out)
      else $error("low expansion select ignored");

   a_proc_blocked: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (primary_select_n_in && !proc_addr_strobe_n_in && ctrl_addr_strobe_n_in && seq_awake)
      |=> $stable(base_r))
      else $error("blocked strobe loaded address");
endmodule
`default_nettype wire

// [verification/sfbs_ctrl_model.sv]
`default_nettype none
module sfbs_ctrl_model (
   input  wire logic        clock_in,
   output logic      [17:0] addr_out,
   output logic             ctrl_addr_strobe_n_out,
   output logic             proc_addr_strobe_n_out,
   output logic             burst_advance_n_out,
   output logic             burst_order_sel_out,
   output logic      [1:0]  byte_write_n_out,
   output logic             global_write_n_out,
   output logic             write_gate_n_out,
   output logic      [2:0]  select_out,
   output logic             output_enable_n_out,
   output logic             sleep_request_out,
   output logic      [17:0] data_lanes_out
);
   timeunit 1ns;
   timeprecision 100ps;
   logic       oe_user_r = 1'b0;
   logic       oe_hold_r = 1'b0;
   logic [3:0] wctl_r    = 4'hF;
   initial begin
      {ctrl_addr_strobe_n_out, proc_addr_strobe_n_out, burst_advance_n_out} = 3'h7;
      burst_order_sel_out = 1'b0;
      {global_write_n_out, write_gate_n_out, byte_write_n_out} = 4'hF;
      select_out = 3'h2;
      output_enable_n_out = 1'b0;
      sleep_request_out = 1'b0;
      addr_out = 18'h00000;
      data_lanes_out = 18'h00000;
   end
   // Selects {primary_n, hi, lo_n}; write qualifiers {global, gate, bytes}
   task automatic set_ctl(input logic [2:0] sel, input logic [3:0] wctl);
      select_out = sel;
      wctl_r = wctl;
   endtask
   task automatic set_oe(input logic v);
      oe_user_r = v;
      output_enable_n_out = v | oe_hold_r;
   endtask
   task automatic set_order(input logic v);
      burst_order_sel_out = v;
   endtask
   task automatic set_sleep(input logic v);
      sleep_request_out = v;
   endtask
   // One bus cycle {ctrl_n, proc_n, adv_n, write}, held to the next edge
   task automatic cyc(input logic [3:0] c, input logic [17:0] a, input logic [17:0] d);
      {ctrl_addr_strobe_n_out, proc_addr_strobe_n_out, burst_advance_n_out} = c[3:1];
      addr_out = a;
      {global_write_n_out, write_gate_n_out, byte_write_n_out} = c[0] ? wctl_r : 4'hF;
      data_lanes_out = c[0] ? d : ~data_lanes_out;
      output_enable_n_out = oe_user_r | oe_hold_r | c[0];
      oe_hold_r = c[0];
      @(posedge clock_in);
      #1;
   endtask
endmodule
`default_nettype wire

// [verification/tb_top.sv]
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [3:0] C_WR = 4'h7, C_RD = 4'h6, P_RD = 4'hA;
   localparam logic [3:0] NX_W = 4'hD, NX = 4'hC, HOLD = 4'hE;
   localparam logic [17:0] B = 18'h000A4;
   logic             clock_in   = 1'b0;
   logic             reset_n_in = 1'b0;
   int               fail_count  = 0;
   int               comparisons = 0;
   int               cycles      = 0;
   wire logic [17:0] addr, wdata, rdata;
   wire logic [2:0]  sel3;
   wire logic [1:0]  bw_n;
   wire logic        cs_n, ps_n, adv_n, ord, gw_n, wg_n, oe_n, slp, doe_n, sel, lowp;
   logic      [17:0] wd [4] = '{18'h1ABCD, 18'h05A5A, 18'h2F0F0, 18'h3C3C3};
   sfbs_ctrl_model sfbs_ctrl_model_i (
      .clock_in(clock_in), .addr_out(addr), .ctrl_addr_strobe_n_out(cs_n),
      .proc_addr_strobe_n_out(ps_n), .burst_advance_n_out(adv_n),
      .burst_order_sel_out(ord), .byte_write_n_out(bw_n), .global_write_n_out(gw_n),
      .write_gate_n_out(wg_n), .select_out(sel3), .output_enable_n_out(oe_n),
      .sleep_request_out(slp), .data_lanes_out(wdata));
   sfbs_top sfbs_top_i (
      .clock_in(clock_in), .reset_n_in(reset_n_in), .addr_in(addr),
      .ctrl_addr_strobe_n_in(cs_n), .proc_addr_strobe_n_in(ps_n),
      .burst_advance_n_in(adv_n), .burst_order_sel_in(ord), .byte_write_n_in(bw_n),
      .global_write_n_in(gw_n), .write_gate_n_in(wg_n), .primary_select_n_in(sel3[2]),
      .expand_select_hi_in(sel3[1]), .expand_select_lo_n_in(sel3[0]),
      .output_enable_n_in(oe_n), .sleep_request_in(slp), .data_lanes_in(wdata),
      .data_lanes_out(rdata), .data_lanes_oe_n_out(doe_n), .selected_out(sel),
      .low_power_out(lowp));
   task automatic end_of_test;
      $display("fail_count %0d comparisons %0d", fail_count, comparisons);
      if (fail_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk_data(input logic [17:0] exp);
      comparisons++;
      if (rdata !== exp) begin
         fail_count++;
         $display("FAIL %0t data %h expected %h", $time, rdata, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp, input string nm);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("FAIL %0t %s", $time, nm);
      end
   endtask
   task automatic t(input logic [3:0] c, input logic [17:0] a, input logic [17:0] d = 18'h00000);
      sfbs_ctrl_model_i.cyc(c, a, d);
   endtask
   task automatic sc(input logic [2:0] s, input logic [3:0] w);
      sfbs_ctrl_model_i.set_ctl(s, w);
   endtask
   task automatic s_write;
      sc(3'h2, 4'h7);
      t(C_WR, B | 18'h1, wd[0]);
      chk_bit(sel, 1'b1, "begin write");
      chk_bit(doe_n, 1'b1, "write float");
      for (int k = 1; k < 4; k++) t(NX_W, B, wd[k]);
      t(HOLD, B);
      sc(3'h6, 4'hF);
      t(C_RD, B);
      chk_bit(sel, 1'b0, "deselect");
   endtask
   task automatic s_read;
      sc(3'h2, 4'hF);
      t(P_RD, B | 18'h1);
      chk_data(wd[0]);
      chk_bit(doe_n, 1'b0, "read drive");
      t(HOLD, B);
      chk_data(wd[0]);
      for (int k = 1; k < 5; k++) begin
         t(NX, B);
         chk_data(wd[k % 4]);
      end
      sfbs_ctrl_model_i.set_oe(1'b1);
      #1 chk_bit(doe_n, 1'b1, "oe async");
      sfbs_ctrl_model_i.set_oe(1'b0);
   endtask
   task automatic s_ileave;
      sfbs_ctrl_model_i.set_order(1'b1);
      t(P_RD, B | 18'h2);
      for (int k = 0; k < 4; k++) begin
         if (k > 0) t(NX, B);
         chk_data(wd[((2 ^ k) + 3) % 4]);
      end
      t(C_RD, B | 18'h3);
      chk_data(wd[2]);
      sfbs_ctrl_model_i.set_order(1'b0);
   endtask
   task automatic s_bytes;
      sc(3'h2, 4'hA);
      t(C_WR, B, 18'h3FFFF);
      sc(3'h2, 4'hB);
      t(C_WR, B | 18'h1);
      chk_data(wd[0]);
      sc(3'h2, 4'h2);
      t(C_WR, B | 18'h2, 18'h15555);
      sc(3'h2, 4'hF);
      t(C_RD, B);
      chk_data({wd[3][17:9], 9'h1FF});
      t(C_RD, B | 18'h2);
      chk_data(18'h15555);
      t(C_RD, B | 18'h1);
      chk_data(wd[0]);
   endtask
   task automatic s_sel;
      logic [2:0] bad [3] = '{3'h0, 3'h3, 3'h0};
      for (int k = 0; k < 3; k++) begin
         sc(3'h2, 4'hF);
         t(P_RD, B | 18'h1);
         sc(3'h6, 4'hF);
         t(P_RD, B | 18'h3);
         chk_data(wd[0]);
         sc(bad[k], 4'hF);
         t(k == 2 ? C_RD : P_RD, B);
         chk_bit(sel, 1'b0, "expand deselect");
         chk_bit(doe_n, 1'b1, "deselect float");
      end
   endtask
   task automatic s_sleep;
      sc(3'h2, 4'hF);
      t(P_RD, B | 18'h1);
      sfbs_ctrl_model_i.set_sleep(1'b1);
      t(HOLD, B);
      chk_bit(lowp, 1'b1, "sleep");
      chk_bit(doe_n, 1'b1, "sleep float");
      sfbs_ctrl_model_i.set_sleep(1'b0);
      t(NX, B);
      chk_bit(lowp, 1'b1, "stay asleep");
      t(C_RD, B | 18'h1);
      chk_bit(lowp, 1'b0, "wake");
      chk_data(wd[0]);
   endtask
   always #5 clock_in = ~clock_in;
   always @(posedge clock_in) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         fail_count++;
         $display("FAIL %0t timeout", $time);
         end_of_test();
      end
   end
   initial begin
      repeat (12) @(posedge clock_in);
      #1;
      chk_bit(sel, 1'b0, "reset select");
      chk_bit(doe_n, 1'b1, "reset float");
      reset_n_in = 1'b1;
      s_write();
      s_read();
      s_ileave();
      s_bytes();
      s_sel();
      s_sleep();
      end_of_test();
   end
endmodule
`default_nettype wire
